// >>> fail_safe_power_state_control.sv
`timescale 1ns/1ns
module fail_safe_power_state_control #(
    parameter int unsigned STARTUP_TO = fsc_pkg::STARTUP_TO_CYC,
    parameter int unsigned RESET_TO = fsc_pkg::RESET_TO_CYC,
    parameter int unsigned MS_CYC = fsc_pkg::CYC_PER_MS
) (
    input wire logic mclk, // System clock
    input wire logic nrst, // Sync reset, active low
    input wire logic battery_present, // Supply on any input
    input wire logic battery_lost_all, // All three inputs lost before reset
    input wire logic wake_in, // Wake pin level
    input wire logic supply_ok, // Above power-up minimum
    input wire logic over_temp, // Junction above warning level
    input wire logic system_clock_fault, // Clock monitor error
    input wire logic supply_overvoltage_flag, // Input overvoltage
    input wire logic por_release, // Internal reset may release
    input wire logic ext_off_cause, // Any other global off cause
    input wire logic internal_regulator_supply_ov_event, // Internal regulator overvoltage
    input wire logic cmd_valid, // Command strobe
    input wire logic [1:0] cmd_code, // 1 wake clear, 2 inhibit set, 3 inhibit clear
    input wire logic [7:0] cmd_data, // Command data byte
    input wire logic ee_done, // EEPROM download complete
    input wire logic ee_crc_err, // CRC mismatch
    input wire logic pbist_done, // Power-up self-test complete
    input wire logic pbist_pass, // Power-up self-test passed
    input wire logic all_uv_ok, // All outputs above UV threshold
    input wire logic [1:0] reset_extension_select, // Extension length select
    input wire logic bist_done, // Analog then logic self-test done
    input wire logic bist_fail, // Either self-test failed
    output logic system_reset_output, // Reset to MCU, low active
    output logic drive_enable_or_irq_output, // Enable/irq pin, low in OFF
    output logic internal_power_on_reset, // High when released
    output logic internal_regulator_supply, // Internal regulators enable
    output logic smps_enable, // Switched regulators enable
    output logic ee_start, // Start EEPROM download
    output logic pbist_start, // Start power-up self-test
    output logic bist_start, // Start extension self-tests
    output logic monitors_en, // Monitoring and protection on
    output logic watchdog_en, // Watchdog enable
    output logic goto_safe, // Leave to SAFE
    output logic goto_active, // Leave normally
    output logic restart_inhibit_latch, // Auto-restart inhibit
    output logic analog_wake_latch, // Filtered wake latched
    output logic [7:0] cause_latch, // Off causes kept over OFF
    output logic [7:0] cause_status, // Copied causes for readout
    output logic [2:0] state_out // Current state
);
    localparam int unsigned CW = 32;
    fsc_pkg::state_e state_r, state_nxt;
    logic [CW-1:0] cnt_r;
    logic [4:0] filt_r;
    logic wake_d_r, armed_r, bist_fail_r, bist_ok_r, copied_r, init_r;

    function automatic logic [CW-1:0] ext_cycles(input logic [1:0] sel);
        ext_cycles = CW'((fsc_pkg::EXT_BASE_MS + fsc_pkg::EXT_STEP_MS * 32'(sel)) * MS_CYC);
    endfunction

    // Command decode; wake clear takes any data, inhibit data values other than the keys are ignored
    wire cmd_wclr = cmd_valid && cmd_code == 2'h1;
    wire cmd_iset = cmd_valid && cmd_code == 2'h2 && cmd_data == fsc_pkg::INH_SET_DATA;
    wire cmd_iclr = cmd_valid && cmd_code == 2'h3 && cmd_data == fsc_pkg::INH_CLR_DATA;
    wire in_off = state_r == fsc_pkg::ST_OFF;
    wire in_init = state_r == fsc_pkg::ST_INIT;
    wire wake_rise = wake_in && !wake_d_r;
    wire wake_valid = filt_r == 5'(fsc_pkg::WAKE_FILT_CYC);
    // Stuck clock or overvoltage keeps reset asserted; only time-out, a power fail or supply loss ends it
    wire init_hold = system_clock_fault || supply_overvoltage_flag;
    wire cnt_exp = cnt_r == '0;
    wire pwr_fail = !in_off && (cmd_wclr || ext_off_cause);
    wire up_ok = supply_ok && !over_temp;

    // Next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            fsc_pkg::ST_OFF: begin
                if (analog_wake_latch && up_ok) state_nxt = fsc_pkg::ST_INIT;
            end
            fsc_pkg::ST_INIT: begin
                if (cnt_exp) state_nxt = fsc_pkg::ST_OFF;
                else if (!init_hold && por_release) state_nxt = fsc_pkg::ST_DL;
            end
            fsc_pkg::ST_DL: begin
                if (ee_done && ee_crc_err) state_nxt = fsc_pkg::ST_OFF;
                else if (ee_done) state_nxt = fsc_pkg::ST_TEMP;
            end
            fsc_pkg::ST_TEMP: begin
                if (!over_temp) state_nxt = fsc_pkg::ST_PBIST;
                else if (cnt_exp) state_nxt = fsc_pkg::ST_OFF;
            end
            fsc_pkg::ST_PBIST: begin
                if (pbist_done && pbist_pass) state_nxt = fsc_pkg::ST_RAMP;
                else if (cnt_exp) state_nxt = fsc_pkg::ST_OFF;
            end
            fsc_pkg::ST_RAMP: begin
                if (all_uv_ok) state_nxt = fsc_pkg::ST_EXT;
                else if (cnt_exp) state_nxt = fsc_pkg::ST_OFF;
            end
            fsc_pkg::ST_EXT: begin
                if (cnt_exp) state_nxt = fsc_pkg::ST_DONE;
            end
            default: state_nxt = fsc_pkg::ST_DONE;
        endcase
        if (pwr_fail || !battery_present) state_nxt = fsc_pkg::ST_OFF;
    end

    wire entering = state_nxt != state_r;
    wire to_off = entering && state_nxt == fsc_pkg::ST_OFF;

    // State and timers
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_r <= fsc_pkg::ST_OFF;
            cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (entering && state_nxt == fsc_pkg::ST_INIT) cnt_r <= CW'(STARTUP_TO);
            else if (entering && state_nxt == fsc_pkg::ST_DL) cnt_r <= CW'(RESET_TO);
            else if (entering && state_nxt == fsc_pkg::ST_EXT) cnt_r <= ext_cycles(reset_extension_select);
            else if (!cnt_exp) cnt_r <= cnt_r - 1'b1;
        end
    end

    // Wake filter and latch; only the filter runs while OFF
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            filt_r <= '0;
            wake_d_r <= 1'b0;
            armed_r <= 1'b1;
            analog_wake_latch <= 1'b0;
        end else begin
            wake_d_r <= wake_in;
            if (!wake_in) filt_r <= '0;
            else if (!wake_valid) filt_r <= filt_r + 1'b1;
            if (wake_rise) armed_r <= 1'b1;
            else if (to_off && restart_inhibit_latch && wake_in) armed_r <= 1'b0;
            if (to_off || (in_off && analog_wake_latch && !up_ok)) analog_wake_latch <= 1'b0;
            else if (in_off && wake_valid && armed_r && battery_present) analog_wake_latch <= 1'b1;
        end
    end

    // Restart inhibit: set wins; reset always clears it, and so does full loss in the first cycle after reset
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            init_r <= 1'b1;
            restart_inhibit_latch <= 1'b0;
        end else begin
            init_r <= 1'b0;
            if (cmd_iset || internal_regulator_supply_ov_event) restart_inhibit_latch <= 1'b1;
            else if (init_r && battery_lost_all) restart_inhibit_latch <= 1'b0;
            else if (cmd_iclr) restart_inhibit_latch <= 1'b0;
        end
    end

    // Cause latch survives OFF; copied into status once the download is done
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cause_latch <= '0;
            cause_status <= '0;
            copied_r <= 1'b0;
        end else begin
            if (in_off && analog_wake_latch && !up_ok) begin
                cause_latch[fsc_pkg::C_UV] <= !supply_ok;
                cause_latch[fsc_pkg::C_OT] <= over_temp;
            end else if (to_off) begin
                cause_latch[fsc_pkg::C_CMD] <= cmd_wclr;
                cause_latch[fsc_pkg::C_EXT] <= ext_off_cause;
                cause_latch[fsc_pkg::C_STARTUP] <= in_init && cnt_exp;
                cause_latch[fsc_pkg::C_CRC] <= state_r == fsc_pkg::ST_DL && ee_crc_err;
                cause_latch[fsc_pkg::C_RESET_TO] <= !in_init && cnt_exp;
            end else if (state_r == fsc_pkg::ST_TEMP && !copied_r) begin
                cause_status <= cause_latch;
                cause_latch <= '0;
            end
            if (in_off) copied_r <= 1'b0;
            else if (state_r == fsc_pkg::ST_TEMP) copied_r <= 1'b1;
        end
    end

    // Extension self-test result; kept after EXT so DONE still knows where to go
    always_ff @(posedge mclk) begin
        if (!nrst || (entering && state_nxt == fsc_pkg::ST_EXT)) begin
            bist_fail_r <= 1'b0;
            bist_ok_r <= 1'b0;
        end else if (state_r == fsc_pkg::ST_EXT && bist_done) begin
            bist_fail_r <= bist_fail;
            bist_ok_r <= !bist_fail;
        end
    end

    // Outputs all registered from next state
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            system_reset_output <= 1'b0;
            drive_enable_or_irq_output <= 1'b0;
            internal_power_on_reset <= 1'b0;
            internal_regulator_supply <= 1'b0;
            smps_enable <= 1'b0;
            ee_start <= 1'b0;
            pbist_start <= 1'b0;
            bist_start <= 1'b0;
            monitors_en <= 1'b0;
            watchdog_en <= 1'b0;
            goto_safe <= 1'b0;
            goto_active <= 1'b0;
            state_out <= 3'h0;
        end else begin
            system_reset_output <= 1'b0;
            drive_enable_or_irq_output <= 1'b0;
            internal_regulator_supply <= state_nxt != fsc_pkg::ST_OFF;
            internal_power_on_reset <= state_nxt != fsc_pkg::ST_OFF && !(state_nxt == fsc_pkg::ST_INIT);
            smps_enable <= state_nxt == fsc_pkg::ST_RAMP || state_nxt == fsc_pkg::ST_EXT
                || state_nxt == fsc_pkg::ST_DONE;
            ee_start <= entering && state_nxt == fsc_pkg::ST_DL;
            pbist_start <= entering && state_nxt == fsc_pkg::ST_PBIST;
            bist_start <= entering && state_nxt == fsc_pkg::ST_EXT;
            monitors_en <= state_nxt != fsc_pkg::ST_OFF;
            watchdog_en <= 1'b0;
            goto_safe <= state_nxt == fsc_pkg::ST_DONE && (bist_fail_r || !bist_ok_r);
            goto_active <= state_nxt == fsc_pkg::ST_DONE && bist_ok_r;
            state_out <= state_nxt;
        end
    end

    off_outputs_a: assert property (@(posedge mclk) disable iff (!nrst)
        $past(state_r) == fsc_pkg::ST_OFF && state_r == fsc_pkg::ST_OFF |-> !system_reset_output && !internal_regulator_supply)
        else $error("outputs active in OFF");
    inh_set_a: assert property (@(posedge mclk) disable iff (!nrst)
        cmd_iset |=> restart_inhibit_latch) else $error("inhibit not set");
    inh_key_a: assert property (@(posedge mclk) disable iff (!nrst)
        cmd_valid && cmd_code == 2'h3 && cmd_data != 8'h55 && restart_inhibit_latch && !init_r |=> restart_inhibit_latch)
        else $error("inhibit cleared by wrong key");
    wclr_off_a: assert property (@(posedge mclk) disable iff (!nrst)
        cmd_wclr && !in_off |=> state_r == fsc_pkg::ST_OFF) else $error("wake clear ignored");
    hold_por_a: assert property (@(posedge mclk) disable iff (!nrst)
        in_init && init_hold && !cnt_exp && battery_present && !pwr_fail |=> state_r != fsc_pkg::ST_DL)
        else $error("left INIT under fault");
    crc_off_a: assert property (@(posedge mclk) disable iff (!nrst)
        state_r == fsc_pkg::ST_DL && ee_done && ee_crc_err |=> in_off ##1 cause_latch[fsc_pkg::C_CRC])
        else $error("crc error not handled");
    smps_gate_a: assert property (@(posedge mclk) disable iff (!nrst)
        smps_enable |-> $past(state_r) == fsc_pkg::ST_PBIST || $past(state_r) >= fsc_pkg::ST_RAMP)
        else $error("regulators before self-test");
    ext_start_a: assert property (@(posedge mclk) disable iff (!nrst)
        state_r == fsc_pkg::ST_RAMP && all_uv_ok && battery_present && !pwr_fail |=> state_r == fsc_pkg::ST_EXT)
        else $error("extension not started");
    wd_off_a: assert property (@(posedge mclk) disable iff (!nrst)
        !watchdog_en) else $error("watchdog active");

    // Reset line to the MCU is never released in these states
    rst_low_a: assert property (@(posedge mclk) disable iff (!nrst)
        !system_reset_output)
        else $error("system reset released");
    // Enable pin stays low, the operating states own it
    drv_low_a: assert property (@(posedge mclk) disable iff (!nrst)
        !drive_enable_or_irq_output)
        else $error("enable pin driven high");
    // Only the wake filter may run while OFF
    off_quiet_a: assert property (@(posedge mclk) disable iff (!nrst)
        in_off |-> !monitors_en && !smps_enable)
        else $error("circuits active in OFF");
    // A clear key with no competing set empties the latch
    inh_clr_a: assert property (@(posedge mclk) disable iff (!nrst)
        cmd_iclr && !cmd_iset && !internal_regulator_supply_ov_event |=> !restart_inhibit_latch)
        else $error("inhibit not cleared");
    // Regulator overvoltage sets the inhibit on its own
    internal_regulator_supply_set_a: assert property (@(posedge mclk) disable iff (!nrst)
        internal_regulator_supply_ov_event |=> restart_inhibit_latch)
        else $error("overvoltage did not set inhibit");
    // The wake latch only sets from a filtered, armed wake
    wake_gate_a: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(analog_wake_latch) |-> $past(wake_valid && armed_r))
        else $error("wake latch set unfiltered");
    // Disarmed after an inhibited failure: no restart without a new edge
    rearm_a: assert property (@(posedge mclk) disable iff (!nrst)
        in_off && !armed_r |-> !analog_wake_latch)
        else $error("restart without fresh wake edge");
    // Failed power-up check drops the latch and stays OFF
    uv_back_a: assert property (@(posedge mclk) disable iff (!nrst)
        in_off && analog_wake_latch && !up_ok |=> in_off && !analog_wake_latch)
        else $error("power-up check ignored");
    // INIT powers the internal regulators but holds reset
    init_reg_a: assert property (@(posedge mclk) disable iff (!nrst)
        in_init |-> internal_regulator_supply && !internal_power_on_reset)
        else $error("INIT outputs wrong");
    // A stuck INIT always ends in OFF
    startup_to_a: assert property (@(posedge mclk) disable iff (!nrst)
        in_init && cnt_exp |=> in_off)
        else $error("start-up time-out ignored");
    // Download runs with internal reset released
    por_dl_a: assert property (@(posedge mclk) disable iff (!nrst)
        state_r == fsc_pkg::ST_DL |-> internal_power_on_reset)
        else $error("download under reset");
    // Hot die keeps RESET until the timer runs out
    temp_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
        state_r == fsc_pkg::ST_TEMP && over_temp && !cnt_exp && battery_present && !pwr_fail
        |=> state_r == fsc_pkg::ST_TEMP)
        else $error("left RESET while hot");
    // Failed extension self-test leads to SAFE
    safe_exit_a: assert property (@(posedge mclk) disable iff (!nrst)
        state_r == fsc_pkg::ST_EXT && cnt_exp && bist_fail_r && battery_present && !pwr_fail |=> goto_safe)
        else $error("self-test failure not routed to SAFE");
    // Supply loss wins over every state
    supply_loss_a: assert property (@(posedge mclk) disable iff (!nrst)
        !battery_present |=> in_off)
        else $error("supply loss ignored");
endmodule

// >>> fsc_pkg.sv
package fsc_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned EXT_BASE_MS = 2;
    localparam int unsigned EXT_STEP_MS = 10;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned WAKE_FILT_CYC = 16;
    localparam int unsigned STARTUP_TO_CYC = 200_000;
    localparam int unsigned RESET_TO_CYC = 200_000;
    localparam logic [7:0] INH_SET_DATA = 8'haa;
    localparam logic [7:0] INH_CLR_DATA = 8'h55;
    // Cause latch bit positions
    localparam int unsigned C_CMD = 0;
    localparam int unsigned C_EXT = 1;
    localparam int unsigned C_UV = 2;
    localparam int unsigned C_OT = 3;
    localparam int unsigned C_STARTUP = 4;
    localparam int unsigned C_CRC = 5;
    localparam int unsigned C_RESET_TO = 6;
    localparam int unsigned C_W = 7;
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_INIT = 3'b001,
        ST_DL = 3'b010,
        ST_TEMP = 3'b011,
        ST_PBIST = 3'b100,
        ST_RAMP = 3'b101,
        ST_EXT = 3'b110,
        ST_DONE = 3'b111
    } state_e;
endpackage

// >>> mcu_model.sv
`timescale 1ns/1ns
module mcu_model (
    input wire logic mclk, // System clock
    output logic cmd_valid, // Command strobe
    output logic [1:0] cmd_code, // Command code
    output logic [7:0] cmd_data // Command data byte
);
    // Idle at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 2'h0;
        cmd_data = 8'h00;
    end
    // One-cycle strobe; idle bytes are inverted so a stale key never matches
    task automatic send(input logic [1:0] code, input logic [7:0] data);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        cmd_data <= data;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        cmd_code <= ~code;
        cmd_data <= ~data;
        @(posedge mclk); // Let the answer settle before the caller looks
    endtask
endmodule

// >>> fail_safe_power_state_control_bench.sv
`timescale 1ns/1ns
module fail_safe_power_state_control_bench;
    logic mclk, nrst, battery_present, battery_lost_all, wake_in, supply_ok, over_temp;
    logic system_clock_fault, supply_overvoltage_flag, por_release, ext_off_cause, internal_regulator_supply_ov_event;
    logic ee_done, ee_crc_err, pbist_done, pbist_pass, all_uv_ok, bist_done, bist_fail;
    logic cmd_valid, system_reset_output, drive_enable_or_irq_output, internal_power_on_reset;
    logic internal_regulator_supply, smps_enable, ee_start, pbist_start, bist_start;
    logic monitors_en, watchdog_en, goto_safe, goto_active, restart_inhibit_latch, analog_wake_latch;
    logic [1:0] cmd_code, reset_extension_select;
    logic [7:0] cmd_data, cause_latch, cause_status;
    logic [2:0] state_out;
    int error_cnt = 0;
    int tests_run = 0;
    int waited;
    int cycles = 0;
    // Short counts keep the run brief; extension is (2 + 10 * select) ms of 10 cycles
    fail_safe_power_state_control #(.STARTUP_TO(50), .RESET_TO(50), .MS_CYC(10))
    fail_safe_power_state_control_i (.*);
    mcu_model mcu_model_i (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data));
    // Clock and time-zero input values
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        {nrst, battery_lost_all, wake_in, over_temp, system_clock_fault, supply_overvoltage_flag} = 6'h00;
        {por_release, ext_off_cause, internal_regulator_supply_ov_event, ee_crc_err, all_uv_ok, bist_fail} = 6'h00;
        {battery_present, supply_ok, ee_done, pbist_done, pbist_pass, bist_done} = 6'h3f;
        reset_extension_select = 2'h0;
    end
    // Hang guard
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Bounded wait for a state; waited holds the cycles spent
    task automatic wait_st(input logic [2:0] s);
        for (waited = 0; waited < 400 && state_out !== s; waited++) @(posedge mclk);
        chk(state_out, s);
    endtask
    task automatic t_reset();
        chk(system_reset_output, 0);
        chk(drive_enable_or_irq_output, 0);
        chk(internal_regulator_supply, 0);
        chk(restart_inhibit_latch, 0);
        $display("test reset done");
    endtask
    task automatic t_inhibit();
        mcu_model_i.send(2'h2, 8'h55);
        chk(restart_inhibit_latch, 0);
        mcu_model_i.send(2'h2, 8'haa);
        chk(restart_inhibit_latch, 1);
        mcu_model_i.send(2'h3, 8'haa);
        chk(restart_inhibit_latch, 1);
        mcu_model_i.send(2'h3, 8'h55);
        chk(restart_inhibit_latch, 0);
        internal_regulator_supply_ov_event <= 1'b1;
        repeat (3) @(posedge mclk);
        internal_regulator_supply_ov_event <= 1'b0;
        chk(restart_inhibit_latch, 1);
        mcu_model_i.send(2'h3, 8'h55);
        $display("test inhibit done");
    endtask
    task automatic t_walk(input logic [1:0] sel, input logic fail);
        reset_extension_select <= sel;
        bist_fail <= fail;
        wake_in <= 1'b1;
        wait_st(3'h1);
        chk(internal_regulator_supply, 1);
        chk(analog_wake_latch, 1);
        over_temp <= 1'b1;
        por_release <= 1'b1;
        wait_st(3'h3);
        chk(internal_power_on_reset, 1);
        repeat (20) @(posedge mclk);
        chk(state_out, 3'h3);
        chk(smps_enable, 0);
        chk(watchdog_en, 0);
        chk(monitors_en, 1);
        over_temp <= 1'b0;
        all_uv_ok <= 1'b1;
        wait_st(3'h6);
        wait_st(3'h7);
        chk(waited >= (2 + 10 * sel) * 10 - 2 && waited <= (2 + 10 * sel) * 10 + 2, 1);
        chk(goto_safe, fail);
        chk(goto_active, !fail);
        {wake_in, all_uv_ok, bist_fail} <= 3'h0;
        mcu_model_i.send(2'h1, 8'h00);
        wait_st(3'h0);
        chk(system_reset_output, 0);
        @(posedge mclk);
        $display("test walk done");
    endtask
    task automatic t_faults();
        supply_ok <= 1'b0;
        wake_in <= 1'b1;
        repeat (40) @(posedge mclk);
        chk(state_out, 3'h0);
        chk(cause_latch[fsc_pkg::C_UV], 1);
        {wake_in, supply_ok, system_clock_fault} <= 3'h3;
        mcu_model_i.send(2'h2, 8'haa);
        wake_in <= 1'b1;
        wait_st(3'h1);
        repeat (5) @(posedge mclk);
        chk(internal_power_on_reset, 0);
        wait_st(3'h0);
        chk(cause_latch[fsc_pkg::C_STARTUP], 1);
        system_clock_fault <= 1'b0;
        repeat (60) @(posedge mclk);
        chk(state_out, 3'h0);
        wake_in <= 1'b0;
        repeat (4) @(posedge mclk);
        wake_in <= 1'b1;
        wait_st(3'h3);
        @(posedge mclk);
        chk(cause_status[fsc_pkg::C_STARTUP], 1);
        wake_in <= 1'b0;
        mcu_model_i.send(2'h1, 8'h00);
        wait_st(3'h0);
        ee_crc_err <= 1'b1;
        mcu_model_i.send(2'h3, 8'h55);
        wake_in <= 1'b1;
        wait_st(3'h2);
        wait_st(3'h0);
        chk(cause_latch[fsc_pkg::C_CRC], 1);
        {wake_in, ee_crc_err} <= 2'h0;
        $display("test faults done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        t_reset();
        t_inhibit();
        t_walk(2'h1, 1'b0);
        t_walk(2'h0, 1'b1);
        t_faults();
        summarize();
    end
endmodule
